// File: hw/cpurs_bank.sv
`timescale 1ns/1ns
module cpurs_bank (
	input  wire logic                  clk,
	input  wire logic                  nrst,
	input  wire cpurs_pkg::cpurs_slots_t wr_mask,
	input  wire cpurs_pkg::cpurs_slots_t wr_data,
	output      cpurs_pkg::cpurs_slots_t slots
);

	cpurs_pkg::cpurs_bank_s st;
	cpurs_pkg::cpurs_bank_s next_st;

	// =====================================================
	// Masked update, bits outside the mask keep their value
	always_comb begin
		next_st = st;
		for (int i = 0; i < cpurs_pkg::NUM_SLOTS; i++) begin
			next_st.slot[i] = (st.slot[i] & ~wr_mask[i]) | (wr_data[i] & wr_mask[i]);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign slots = st.slot;

endmodule

// File: hw/cpurs_pkg.sv
package cpurs_pkg;

	// =====================================================
	// Widths
	localparam int unsigned ADDR_W    = 24;
	localparam int unsigned DATA_W    = 16;
	localparam int unsigned BYTE_W    = 8;
	localparam int unsigned BUS_W     = 32;
	localparam int unsigned FLAG_W    = 16;
	localparam int unsigned MODE_W    = 8;
	localparam int unsigned NUM_SLOTS = 8;
	localparam int unsigned NUM_CH    = 2;
	localparam int unsigned SWI_W     = 6;

	typedef logic [ADDR_W-1:0] cpurs_addr_t;
	typedef logic [DATA_W-1:0] cpurs_data_t;
	typedef logic [BUS_W-1:0]  cpurs_word_t;
	typedef logic [FLAG_W-1:0] cpurs_flag_t;
	typedef logic [MODE_W-1:0] cpurs_mode_t;
	typedef logic [NUM_SLOTS-1:0][ADDR_W-1:0] cpurs_slots_t;

	// =====================================================
	// Flag word layout
	localparam int unsigned FLAG_BANK_BIT  = 4;
	localparam int unsigned FLAG_STACK_BIT = 7;
	localparam cpurs_flag_t FLAG_WR_MASK   = 16'h70ff;
	localparam logic [SWI_W-1:0] SWI_CLR_MAX = 6'h1f;

	// =====================================================
	// Field masks inside a 24-bit slot
	localparam cpurs_addr_t MASK_ADDR  = 24'hffffff;
	localparam cpurs_addr_t MASK_DATA  = 24'h00ffff;
	localparam cpurs_addr_t MASK_UPPER = 24'h00ff00;
	localparam cpurs_addr_t MASK_LOWER = 24'h0000ff;

	// =====================================================
	// Reset values
	localparam cpurs_addr_t RST_ADDR = 24'h000000;
	localparam cpurs_data_t RST_DATA = 16'h0000;
	localparam cpurs_flag_t RST_FLAG = 16'h0000;
	localparam cpurs_mode_t RST_MODE = 8'h00;
	localparam cpurs_word_t RST_WORD = 32'h00000000;

	// =====================================================
	// Slot positions inside one bank
	localparam logic [2:0] SLOT_D0 = 3'h0;
	localparam logic [2:0] SLOT_D1 = 3'h1;
	localparam logic [2:0] SLOT_D2 = 3'h2;
	localparam logic [2:0] SLOT_D3 = 3'h3;
	localparam logic [2:0] SLOT_AR0 = 3'h4;
	localparam logic [2:0] SLOT_AR1 = 3'h5;
	localparam logic [2:0] SLOT_ST = 3'h6;
	localparam logic [2:0] SLOT_FR = 3'h7;

	// =====================================================
	// Register selector codes
	typedef enum logic [4:0] {
		id_data_reg_first        = 5'h00,
		id_data_reg_second       = 5'h01,
		id_data_reg_third        = 5'h02,
		id_data_reg_fourth       = 5'h03,
		id_addr_reg_first        = 5'h04,
		id_addr_reg_second       = 5'h05,
		id_static_base           = 5'h06,
		id_frame_base            = 5'h07,
		id_prog_counter          = 5'h08,
		id_vector_table_base     = 5'h09,
		id_user_stack_ptr        = 5'h0a,
		id_irq_stack_ptr         = 5'h0b,
		id_flag_word             = 5'h0c,
		id_fast_irq_flag_save    = 5'h0d,
		id_fast_irq_pc_save      = 5'h0e,
		id_fast_irq_vector       = 5'h0f,
		id_dma_ch0_mode          = 5'h10,
		id_dma_ch1_mode          = 5'h11,
		id_dma_ch0_count         = 5'h12,
		id_dma_ch1_count         = 5'h13,
		id_dma_ch0_count_reload  = 5'h14,
		id_dma_ch1_count_reload  = 5'h15,
		id_dma_ch0_mem_addr      = 5'h16,
		id_dma_ch1_mem_addr      = 5'h17,
		id_first_data_upper_byte = 5'h18,
		id_first_data_lower_byte = 5'h19,
		id_second_data_upper_byte = 5'h1a,
		id_second_data_lower_byte = 5'h1b,
		id_low_wide_pair         = 5'h1c,
		id_high_wide_pair        = 5'h1d,
		id_active_stack_ptr      = 5'h1e,
		id_unmapped              = 5'h1f
	} cpurs_reg_id_e;

	// =====================================================
	// State records
	typedef struct packed {
		cpurs_slots_t slot;
	} cpurs_bank_s;

	typedef struct packed {
		cpurs_addr_t                    prog_counter;
		cpurs_addr_t                    vector_table_base;
		cpurs_addr_t                    user_stack_ptr;
		cpurs_addr_t                    irq_stack_ptr;
		cpurs_flag_t                    flag_word;
		cpurs_flag_t                    fast_irq_flag_save;
		cpurs_addr_t                    fast_irq_pc_save;
		cpurs_addr_t                    fast_irq_vector;
		logic [NUM_CH-1:0][MODE_W-1:0]  dma_mode;
		logic [NUM_CH-1:0][DATA_W-1:0]  dma_count;
		logic [NUM_CH-1:0][DATA_W-1:0]  dma_count_reload;
		logic [NUM_CH-1:0][ADDR_W-1:0]  dma_mem_addr;
		cpurs_word_t                    rd_data;
		logic                           rd_valid;
	} cpurs_state_s;

endpackage

// File: hw/cpurs_regset.sv
`timescale 1ns/1ns
module cpurs_regset (
	input  wire logic                     clk,
	input  wire logic                     nrst,
	input  wire logic                     wr_en,
	input  wire cpurs_pkg::cpurs_reg_id_e wr_id,
	input  wire cpurs_pkg::cpurs_word_t   wr_data,
	input  wire logic                     rd_en,
	input  wire cpurs_pkg::cpurs_reg_id_e rd_id,
	output      cpurs_pkg::cpurs_word_t   rd_data,
	output      logic                     rd_valid,
	input  wire logic                     fast_irq_take,
	input  wire logic                     hw_irq_ack,
	input  wire logic                     sw_int_exec,
	input  wire logic [5:0]               sw_int_num,
	input  wire logic [1:0]               dma_reload,
	output      cpurs_pkg::cpurs_addr_t   prog_counter,
	output      cpurs_pkg::cpurs_addr_t   vector_table_base,
	output      cpurs_pkg::cpurs_flag_t   flag_word,
	output      logic                     bank_sel,
	output      logic                     stack_sel
);

	cpurs_pkg::cpurs_state_s st;
	cpurs_pkg::cpurs_state_s next_st;

	cpurs_pkg::cpurs_slots_t slots0;
	cpurs_pkg::cpurs_slots_t slots1;
	cpurs_pkg::cpurs_slots_t mask0;
	cpurs_pkg::cpurs_slots_t mask1;
	cpurs_pkg::cpurs_slots_t bank_wdata;

	// =====================================================
	// Banked registers
	// two bank copies
	cpurs_bank u_bank0 (
		.clk     (clk),
		.nrst    (nrst),
		.wr_mask (mask0),
		.wr_data (bank_wdata),
		.slots   (slots0)
	);

	cpurs_bank u_bank1 (
		.clk     (clk),
		.nrst    (nrst),
		.wr_mask (mask1),
		.wr_data (bank_wdata),
		.slots   (slots1)
	);

	// =====================================================
	// Next-state logic
	always_comb begin
		cpurs_pkg::cpurs_slots_t vis;
		cpurs_pkg::cpurs_slots_t wmask;
		cpurs_pkg::cpurs_word_t  rval;
		cpurs_pkg::cpurs_addr_t  sp_active;
		cpurs_pkg::cpurs_addr_t  w24;
		cpurs_pkg::cpurs_addr_t  wlo;
		cpurs_pkg::cpurs_addr_t  whi;
		logic                    bsel;
		logic                    ssel;
		logic                    ch;
		vis       = '0;
		wmask     = '0;
		rval      = cpurs_pkg::RST_WORD;
		sp_active = cpurs_pkg::RST_ADDR;
		w24       = wr_data[23:0];
		wlo       = {8'h00, wr_data[15:0]};
		whi       = {8'h00, wr_data[31:16]};
		bsel      = st.flag_word[cpurs_pkg::FLAG_BANK_BIT];
		ssel      = st.flag_word[cpurs_pkg::FLAG_STACK_BIT];
		ch        = wr_id[0];
		next_st   = st;
		bank_wdata = '0;

		if (bsel) begin
			vis = slots1;
		end else begin
			vis = slots0;
		end

		if (ssel) begin
			sp_active = st.user_stack_ptr;
		end else begin
			sp_active = st.irq_stack_ptr;
		end

		// -------------------------------------------------
		// Write decode
		// write takes effect next edge
		if (wr_en) begin
			case (wr_id)
				cpurs_pkg::id_data_reg_first,
				cpurs_pkg::id_data_reg_second,
				cpurs_pkg::id_data_reg_third,
				cpurs_pkg::id_data_reg_fourth: begin
					wmask[wr_id[2:0]]      = cpurs_pkg::MASK_DATA;
					bank_wdata[wr_id[2:0]] = wlo;
				end
				cpurs_pkg::id_addr_reg_first,
				cpurs_pkg::id_addr_reg_second,
				cpurs_pkg::id_static_base,
				cpurs_pkg::id_frame_base: begin
					wmask[wr_id[2:0]]      = cpurs_pkg::MASK_ADDR;
					bank_wdata[wr_id[2:0]] = w24;
				end
				cpurs_pkg::id_first_data_upper_byte: begin
					wmask[cpurs_pkg::SLOT_D0]      = cpurs_pkg::MASK_UPPER;
					bank_wdata[cpurs_pkg::SLOT_D0] = {8'h00, wr_data[7:0], 8'h00};
				end
				cpurs_pkg::id_first_data_lower_byte: begin
					wmask[cpurs_pkg::SLOT_D0]      = cpurs_pkg::MASK_LOWER;
					bank_wdata[cpurs_pkg::SLOT_D0] = {16'h0000, wr_data[7:0]};
				end
				cpurs_pkg::id_second_data_upper_byte: begin
					wmask[cpurs_pkg::SLOT_D1]      = cpurs_pkg::MASK_UPPER;
					bank_wdata[cpurs_pkg::SLOT_D1] = {8'h00, wr_data[7:0], 8'h00};
				end
				cpurs_pkg::id_second_data_lower_byte: begin
					wmask[cpurs_pkg::SLOT_D1]      = cpurs_pkg::MASK_LOWER;
					bank_wdata[cpurs_pkg::SLOT_D1] = {16'h0000, wr_data[7:0]};
				end
				// pair writes, higher register on top
				cpurs_pkg::id_low_wide_pair: begin
					wmask[cpurs_pkg::SLOT_D0]      = cpurs_pkg::MASK_DATA;
					wmask[cpurs_pkg::SLOT_D2]      = cpurs_pkg::MASK_DATA;
					bank_wdata[cpurs_pkg::SLOT_D0] = wlo;
					bank_wdata[cpurs_pkg::SLOT_D2] = whi;
				end
				cpurs_pkg::id_high_wide_pair: begin
					wmask[cpurs_pkg::SLOT_D1]      = cpurs_pkg::MASK_DATA;
					wmask[cpurs_pkg::SLOT_D3]      = cpurs_pkg::MASK_DATA;
					bank_wdata[cpurs_pkg::SLOT_D1] = wlo;
					bank_wdata[cpurs_pkg::SLOT_D3] = whi;
				end
				cpurs_pkg::id_prog_counter: next_st.prog_counter = w24;
				cpurs_pkg::id_vector_table_base: next_st.vector_table_base = w24;
				cpurs_pkg::id_user_stack_ptr: next_st.user_stack_ptr = w24;
				cpurs_pkg::id_irq_stack_ptr: next_st.irq_stack_ptr = w24;
				cpurs_pkg::id_active_stack_ptr: begin
					if (ssel) begin
						next_st.user_stack_ptr = w24;
					end else begin
						next_st.irq_stack_ptr = w24;
					end
				end
				cpurs_pkg::id_flag_word:
					next_st.flag_word = wr_data[15:0] & cpurs_pkg::FLAG_WR_MASK;
				cpurs_pkg::id_fast_irq_flag_save:
					next_st.fast_irq_flag_save = wr_data[15:0];
				cpurs_pkg::id_fast_irq_pc_save: next_st.fast_irq_pc_save = w24;
				cpurs_pkg::id_fast_irq_vector: next_st.fast_irq_vector = w24;
				cpurs_pkg::id_dma_ch0_mode,
				cpurs_pkg::id_dma_ch1_mode: next_st.dma_mode[ch] = wr_data[7:0];
				cpurs_pkg::id_dma_ch0_count,
				cpurs_pkg::id_dma_ch1_count: next_st.dma_count[ch] = wr_data[15:0];
				cpurs_pkg::id_dma_ch0_count_reload,
				cpurs_pkg::id_dma_ch1_count_reload:
					next_st.dma_count_reload[ch] = wr_data[15:0];
				cpurs_pkg::id_dma_ch0_mem_addr,
				cpurs_pkg::id_dma_ch1_mem_addr: next_st.dma_mem_addr[ch] = w24;
				default: next_st = st;
			endcase
		end

		// Only the visible bank takes a write
		if (bsel) begin
			mask0 = '0;
			mask1 = wmask;
		end else begin
			mask0 = wmask;
			mask1 = '0;
		end

		// -------------------------------------------------
		// Hardware events override a same-cycle write
		// reload count from reload value
		for (int c = 0; c < cpurs_pkg::NUM_CH; c++) begin
			if (dma_reload[c]) begin
				next_st.dma_count[c] = st.dma_count_reload[c];
			end
		end

		if (fast_irq_take) begin
			next_st.fast_irq_flag_save = st.flag_word;
			next_st.fast_irq_pc_save = st.prog_counter;
			next_st.prog_counter = st.fast_irq_vector;
		end

		if (hw_irq_ack || (sw_int_exec && (sw_int_num <= cpurs_pkg::SWI_CLR_MAX))) begin
			next_st.flag_word[cpurs_pkg::FLAG_STACK_BIT] = 1'b0;
		end

		// -------------------------------------------------
		// Read decode
		// all visible registers readable
		case (rd_id)
			cpurs_pkg::id_data_reg_first,
			cpurs_pkg::id_data_reg_second,
			cpurs_pkg::id_data_reg_third,
			cpurs_pkg::id_data_reg_fourth: rval = {16'h0000, vis[rd_id[2:0]][15:0]};
			cpurs_pkg::id_addr_reg_first,
			cpurs_pkg::id_addr_reg_second,
			cpurs_pkg::id_static_base,
			cpurs_pkg::id_frame_base: rval = {8'h00, vis[rd_id[2:0]]};
			cpurs_pkg::id_first_data_upper_byte:
				rval = {24'h000000, vis[cpurs_pkg::SLOT_D0][15:8]};
			cpurs_pkg::id_first_data_lower_byte:
				rval = {24'h000000, vis[cpurs_pkg::SLOT_D0][7:0]};
			cpurs_pkg::id_second_data_upper_byte:
				rval = {24'h000000, vis[cpurs_pkg::SLOT_D1][15:8]};
			cpurs_pkg::id_second_data_lower_byte:
				rval = {24'h000000, vis[cpurs_pkg::SLOT_D1][7:0]};
			// pair reads, higher register on top
			cpurs_pkg::id_low_wide_pair:
				rval = {vis[cpurs_pkg::SLOT_D2][15:0], vis[cpurs_pkg::SLOT_D0][15:0]};
			cpurs_pkg::id_high_wide_pair:
				rval = {vis[cpurs_pkg::SLOT_D3][15:0], vis[cpurs_pkg::SLOT_D1][15:0]};
			cpurs_pkg::id_prog_counter: rval = {8'h00, st.prog_counter};
			cpurs_pkg::id_vector_table_base: rval = {8'h00, st.vector_table_base};
			cpurs_pkg::id_user_stack_ptr: rval = {8'h00, st.user_stack_ptr};
			cpurs_pkg::id_irq_stack_ptr: rval = {8'h00, st.irq_stack_ptr};
			cpurs_pkg::id_active_stack_ptr: rval = {8'h00, sp_active};
			cpurs_pkg::id_flag_word: rval = {16'h0000, st.flag_word};
			cpurs_pkg::id_fast_irq_flag_save: rval = {16'h0000, st.fast_irq_flag_save};
			cpurs_pkg::id_fast_irq_pc_save: rval = {8'h00, st.fast_irq_pc_save};
			cpurs_pkg::id_fast_irq_vector: rval = {8'h00, st.fast_irq_vector};
			cpurs_pkg::id_dma_ch0_mode,
			cpurs_pkg::id_dma_ch1_mode: rval = {24'h000000, st.dma_mode[rd_id[0]]};
			cpurs_pkg::id_dma_ch0_count,
			cpurs_pkg::id_dma_ch1_count: rval = {16'h0000, st.dma_count[rd_id[0]]};
			cpurs_pkg::id_dma_ch0_count_reload,
			cpurs_pkg::id_dma_ch1_count_reload:
				rval = {16'h0000, st.dma_count_reload[rd_id[0]]};
			cpurs_pkg::id_dma_ch0_mem_addr,
			cpurs_pkg::id_dma_ch1_mem_addr: rval = {8'h00, st.dma_mem_addr[rd_id[0]]};
			default: rval = cpurs_pkg::RST_WORD;
		endcase

		next_st.rd_valid = rd_en;
		if (rd_en) begin
			next_st.rd_data = rval;
		end
	end

	// =====================================================
	// State register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st.prog_counter       <= cpurs_pkg::RST_ADDR;
			st.vector_table_base  <= cpurs_pkg::RST_ADDR;
			st.user_stack_ptr     <= cpurs_pkg::RST_ADDR;
			st.irq_stack_ptr      <= cpurs_pkg::RST_ADDR;
			st.flag_word          <= cpurs_pkg::RST_FLAG;
			st.fast_irq_flag_save <= cpurs_pkg::RST_FLAG;
			st.fast_irq_pc_save   <= cpurs_pkg::RST_ADDR;
			st.fast_irq_vector    <= cpurs_pkg::RST_ADDR;
			st.dma_mode           <= {cpurs_pkg::RST_MODE, cpurs_pkg::RST_MODE};
			st.dma_count          <= {cpurs_pkg::RST_DATA, cpurs_pkg::RST_DATA};
			st.dma_count_reload   <= {cpurs_pkg::RST_DATA, cpurs_pkg::RST_DATA};
			st.dma_mem_addr       <= {cpurs_pkg::RST_ADDR, cpurs_pkg::RST_ADDR};
			st.rd_data            <= cpurs_pkg::RST_WORD;
			st.rd_valid           <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	// =====================================================
	// Outputs
	assign rd_data           = st.rd_data;
	assign rd_valid          = st.rd_valid;
	assign prog_counter      = st.prog_counter;
	assign vector_table_base = st.vector_table_base;
	assign flag_word         = st.flag_word;
	assign bank_sel          = st.flag_word[cpurs_pkg::FLAG_BANK_BIT];
	assign stack_sel         = st.flag_word[cpurs_pkg::FLAG_STACK_BIT];

endmodule

// File: sim/cpu_register_set_banked_test.sv
`timescale 1ns/1ns
module cpu_register_set_banked_test;
	logic                     clk, nrst, wr_en, rd_en, ev_go, rd_valid, bank_sel, stack_sel;
	logic                     fast_irq_take, hw_irq_ack, sw_int_exec;
	cpurs_pkg::cpurs_reg_id_e wr_id, rd_id;
	cpurs_pkg::cpurs_word_t   wr_data, rd_data;
	logic [4:0]               ev_kind;
	logic [5:0]               ev_num, sw_int_num;
	logic [1:0]               dma_reload;
	cpurs_pkg::cpurs_addr_t   prog_counter, vector_table_base;
	cpurs_pkg::cpurs_flag_t   flag_word;
	int                       err_count, n_tests, cycles;

	cpurs_regset i_dut (.clk, .nrst, .wr_en, .wr_id, .wr_data, .rd_en, .rd_id, .rd_data,
		.rd_valid, .fast_irq_take, .hw_irq_ack, .sw_int_exec, .sw_int_num, .dma_reload,
		.prog_counter, .vector_table_base, .flag_word, .bank_sel, .stack_sel);
	cpurs_cpu_model i_cpu (.clk, .nrst, .ev_go, .ev_kind, .ev_num, .fast_irq_take,
		.hw_irq_ack, .sw_int_exec, .sw_int_num, .dma_reload);

	// =====================================================
	// Helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [4:0] id, input logic [31:0] d);
		rd_en = 1'b0;
		wr_en = 1'b1;
		wr_id = cpurs_pkg::cpurs_reg_id_e'(id);
		wr_data = d;
		@(posedge clk);
		#1;
	endtask

	task automatic rd(input logic [4:0] id, input logic [31:0] exp);
		wr_en = 1'b0;
		rd_en = 1'b1;
		rd_id = cpurs_pkg::cpurs_reg_id_e'(id);
		@(posedge clk);
		#1;
		chk(32'(rd_valid), 32'h1, "read valid");
		chk(rd_data, exp, "read data");
	endtask

	task automatic fire(input logic [4:0] k, input logic [5:0] n);
		wr_en = 1'b0;
		rd_en = 1'b0;
		ev_go = 1'b1;
		ev_kind = k;
		ev_num = n;
		@(posedge clk);
		#1;
		ev_go = 1'b0;
		@(posedge clk);
		#1;
	endtask

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// =====================================================
	// Scenarios
	task automatic t_reset();
		chk(32'(prog_counter), 32'h0, "pc after reset");
		chk(32'(flag_word), 32'h0, "flags after reset");
		chk(32'(vector_table_base), 32'h0, "table base after reset");
		chk(32'({bank_sel, stack_sel}), 32'h0, "selects after reset");
		rd(5'h0f, 32'h0);
		$display("test reset done");
	endtask

	task automatic t_widths();
		logic [31:0] m;
		for (int i = 0; i < 24; i++) begin
			case (i)
				0, 1, 2, 3, 13, 18, 19, 20, 21: m = 32'h0000ffff;
				12: m = 32'h000070ff;
				16, 17: m = 32'h000000ff;
				default: m = 32'h00ffffff;
			endcase
			wr(5'(i), 32'hdcba9876);
			rd(5'(i), 32'hdcba9876 & m);
		end
		wr(5'h1f, 32'hffffffff);
		rd(5'h1f, 32'h0);
		wr(5'h0c, 32'h0);
		$display("test widths done");
	endtask

	task automatic t_bytes();
		for (int k = 0; k < 2; k++) begin
			wr(5'(k), 32'h1234);
			wr(5'(24 + 2 * k), 32'hffffffab);
			rd(5'(k), 32'hab34);
			wr(5'(25 + 2 * k), 32'hcd);
			rd(5'(k), 32'habcd);
			rd(5'(24 + 2 * k), 32'hab);
			rd(5'(25 + 2 * k), 32'hcd);
		end
		wr(5'h1c, 32'h11112222);
		rd(5'h00, 32'h2222);
		rd(5'h02, 32'h1111);
		wr(5'h1d, 32'h33334444);
		rd(5'h01, 32'h4444);
		rd(5'h03, 32'h3333);
		rd(5'h1d, 32'h33334444);
		$display("test bytes and pairs done");
	endtask

	task automatic t_banks();
		for (int i = 0; i < 8; i++)
			wr(5'(i), 32'h100 + i);
		wr(5'h0c, 32'h10);
		chk(32'(bank_sel), 32'h1, "bank select");
		for (int i = 0; i < 8; i++) begin
			rd(5'(i), 32'h0);
			wr(5'(i), 32'h200 + i);
		end
		wr(5'h0c, 32'h0);
		for (int i = 0; i < 8; i++)
			rd(5'(i), 32'h100 + i);
		wr(5'h0c, 32'h10);
		rd(5'h07, 32'h207);
		wr(5'h0c, 32'h0);
		$display("test banks done");
	endtask

	task automatic t_stack();
		logic [5:0] nums [4];
		nums = '{6'h1f, 6'h20, 6'h00, 6'h3f};
		wr(5'h0a, 32'h100);
		wr(5'h0b, 32'h200);
		rd(5'h1e, 32'h200);
		wr(5'h0c, 32'h80);
		rd(5'h1e, 32'h100);
		wr(5'h1e, 32'h300);
		rd(5'h0a, 32'h300);
		fire(5'h02, 6'h00);
		chk(32'(stack_sel), 32'h0, "ack clears stack flag");
		for (int j = 0; j < 4; j++) begin
			wr(5'h0c, 32'h80);
			fire(5'h04, nums[j]);
			chk(32'(stack_sel), 32'(nums[j] > 6'h1f), "soft irq stack flag");
		end
		wr(5'h0c, 32'h0);
		$display("test stack done");
	endtask

	task automatic t_fast();
		wr(5'h0f, 32'h00abc0);
		wr(5'h08, 32'h123456);
		wr(5'h0c, 32'h3011);
		fire(5'h01, 6'h00);
		chk(32'(prog_counter), 32'h00abc0, "pc from vector");
		chk(32'(flag_word), 32'h3011, "flags kept");
		rd(5'h0e, 32'h123456);
		rd(5'h0d, 32'h3011);
		wr_en = 1'b1;
		wr_id = cpurs_pkg::id_prog_counter;
		wr_data = 32'h654321;
		rd_id = cpurs_pkg::id_prog_counter;
		@(posedge clk);
		#1;
		chk(rd_data, 32'h00abc0, "read sees old pc");
		chk(32'(prog_counter), 32'h654321, "pc written");
		wr(5'h0c, 32'h0);
		$display("test fast irq done");
	endtask

	task automatic t_dma();
		wr(5'h12, 32'h5);
		wr(5'h14, 32'h77);
		wr(5'h13, 32'h6);
		wr(5'h15, 32'h88);
		fire(5'h08, 6'h00);
		rd(5'h12, 32'h77);
		rd(5'h13, 32'h6);
		fire(5'h18, 6'h00);
		rd(5'h13, 32'h88);
		$display("test dma reload done");
	endtask

	// =====================================================
	// Clock, watchdog and main sequence
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		cycles = 0;
		forever begin
			@(posedge clk);
			cycles++;
			if (cycles > 3000) begin
				err_count++;
				$display("Error at %0t: run did not finish", $time);
				wrap_up();
			end
		end
	end

	initial begin
		nrst = 1'b0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		ev_go = 1'b0;
		ev_kind = 5'h00;
		ev_num = 6'h00;
		wr_id = cpurs_pkg::id_data_reg_first;
		rd_id = cpurs_pkg::id_data_reg_first;
		wr_data = 32'h0;
		err_count = 0;
		n_tests = 0;
		repeat (2) @(posedge clk);
		#1;
		nrst = 1'b1;
		t_reset();
		t_widths();
		t_bytes();
		t_banks();
		t_stack();
		t_fast();
		t_dma();
		wrap_up();
	end
endmodule

// File: sim/cpurs_cpu_model.sv
`timescale 1ns/1ns
module cpurs_cpu_model (
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic       ev_go,
	input  wire logic [4:0] ev_kind,
	input  wire logic [5:0] ev_num,
	output      logic       fast_irq_take,
	output      logic       hw_irq_ack,
	output      logic       sw_int_exec,
	output      logic [5:0] sw_int_num,
	output      logic [1:0] dma_reload
);
	// Each request becomes one-cycle pulses; the number is scrambled when unused
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fast_irq_take <= 1'b0;
			hw_irq_ack    <= 1'b0;
			sw_int_exec   <= 1'b0;
			sw_int_num    <= 6'h00;
			dma_reload    <= 2'h0;
		end else begin
			fast_irq_take <= ev_go & ev_kind[0];
			hw_irq_ack    <= ev_go & ev_kind[1];
			sw_int_exec   <= ev_go & ev_kind[2];
			dma_reload    <= {2{ev_go}} & ev_kind[4:3];
			sw_int_num    <= ev_go ? ev_num : ~sw_int_num;
		end
	end
endmodule

// File: sim/cpurs_regset_asserts.sv
`timescale 1ns/1ns
module cpurs_regset_asserts (
	input wire logic                     clk,
	input wire logic                     nrst,
	input wire logic                     wr_en,
	input wire cpurs_pkg::cpurs_reg_id_e wr_id,
	input wire cpurs_pkg::cpurs_word_t   wr_data,
	input wire logic                     rd_en,
	input wire cpurs_pkg::cpurs_reg_id_e rd_id,
	input wire cpurs_pkg::cpurs_word_t   rd_data,
	input wire logic                     rd_valid,
	input wire logic                     fast_irq_take,
	input wire logic                     hw_irq_ack,
	input wire logic                     sw_int_exec,
	input wire logic [5:0]               sw_int_num,
	input wire logic [1:0]               dma_reload,
	input wire cpurs_pkg::cpurs_addr_t   prog_counter,
	input wire cpurs_pkg::cpurs_addr_t   vector_table_base,
	input wire cpurs_pkg::cpurs_flag_t   flag_word,
	input wire logic                     bank_sel,
	input wire logic                     stack_sel
);
	logic [15:0] wd_lo;
	logic [23:0] wd_addr;
	assign wd_lo   = wr_data[15:0];
	assign wd_addr = wr_data[23:0];

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	// =====================================================
	// Sequences
	sequence s_pc_wr;
		wr_en && wr_id == cpurs_pkg::id_prog_counter && !fast_irq_take;
	endsequence
	sequence s_fast_only;
		fast_irq_take && !wr_en && !hw_irq_ack && !sw_int_exec;
	endsequence
	sequence s_stack_clr;
		hw_irq_ack || (sw_int_exec && sw_int_num <= 6'h1f);
	endsequence

	// =====================================================
	// Properties
	rd_pulse_a:
		assert property (rd_en |=> rd_valid) else $error("read not answered");
	rd_quiet_a:
		assert property (!rd_en |=> !rd_valid && $stable(rd_data)) else $error("idle read moved");
	pc_write_a:
		assert property (s_pc_wr |=> prog_counter == $past(wd_addr)) else $error("pc write lost");
	pc_read_a:
		assert property (rd_en && rd_id == cpurs_pkg::id_prog_counter
			|=> rd_data == {8'h00, $past(prog_counter)}) else $error("pc read wrong");
	irq_flag_keep_a:
		assert property (s_fast_only |=> $stable(flag_word)) else $error("fast irq hit flags");
	stack_clear_a:
		assert property (s_stack_clr |=> !stack_sel) else $error("stack flag not cleared");
	sw_high_keep_a:
		assert property (sw_int_exec && sw_int_num > 6'h1f && !hw_irq_ack && !wr_en && stack_sel
			|=> stack_sel) else $error("high soft irq cleared stack flag");
	flag_write_a:
		assert property (wr_en && wr_id == cpurs_pkg::id_flag_word && !hw_irq_ack && !sw_int_exec
			|=> flag_word == ($past(wd_lo) & cpurs_pkg::FLAG_WR_MASK)) else $error("flag write");
	bank_sel_a:
		assert property (!(wr_en && wr_id == cpurs_pkg::id_flag_word)
			|=> $stable(bank_sel)) else $error("bank moved without flag write");
	stack_sel_a:
		assert property (!(wr_en && wr_id == cpurs_pkg::id_flag_word) && !hw_irq_ack && !sw_int_exec
			|=> $stable(stack_sel)) else $error("stack select moved on its own");
	vtb_write_a:
		assert property (wr_en && wr_id == cpurs_pkg::id_vector_table_base
			|=> vector_table_base == $past(wd_addr)) else $error("table base write lost");
	reset_state_a:
		assert property ($rose(nrst) |-> prog_counter == 24'h000000 && flag_word == 16'h0000
			&& !rd_valid) else $error("state not cleared by reset");
endmodule

bind cpurs_regset cpurs_regset_asserts i_chk (.clk, .nrst, .wr_en, .wr_id, .wr_data, .rd_en,
	.rd_id, .rd_data, .rd_valid, .fast_irq_take, .hw_irq_ack, .sw_int_exec, .sw_int_num,
	.dma_reload, .prog_counter, .vector_table_base, .flag_word, .bank_sel, .stack_sel);
